// [design/sram_ctl_map.svh]
// timing counts and reset values for the single-bit static memory controller
// assumes a 40 MHz reference clock (25 ns period)
`ifndef SRAM_CTL_MAP_SVH
`define SRAM_CTL_MAP_SVH

`define CLK_PERIOD_NS 25
// slowest speed grade read cycle time, ns
`define READ_CYCLE_TIME_NS 35
// least time rounds up, never below one cycle
`define READ_CYCLE_CYC (((`READ_CYCLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  ((`READ_CYCLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define DESELECT_TO_RETENTION_DELAY_NS 0
`define DESELECT_TO_RETENTION_CYC 1
// recovery equals one read cycle time
`define RETENTION_RECOVERY_DELAY_CYC `READ_CYCLE_CYC
// write pulse width (slowest grade) 20 ns
`define WRITE_PULSE_NS 20
`define WRITE_PULSE_CYC (((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define CNT_W 4
`define CELL_INDEX_W 16
`define CELL_INDEX_RST 16'h0000
`endif

// [design/sram_ctl_pkg.sv]
// types for the single-bit static memory controller
// used with sram_ctl_map.svh
package sram_ctl_pkg;
  `include "sram_ctl_map.svh"

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b00_0001,
    ST_SETUP  = 6'b00_0010,
    ST_READ   = 6'b00_0100,
    ST_WRITE  = 6'b00_1000,
    ST_RETAIN = 6'b01_0000,
    ST_RECOV  = 6'b10_0000
  } ctl_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [`CELL_INDEX_W-1:0] cell_index;
    logic wdata;
  } mem_req_t;

  typedef struct packed {
    logic sel_b;
    logic wr_b;
    logic [`CELL_INDEX_W-1:0] cell_index;
    logic din;
  } mem_pins_t;

  typedef struct packed {
    ctl_state_t st;
    logic [`CNT_W-1:0] cnt;
    mem_pins_t pins;
    logic busy;
    logic rvalid;
    logic rdata;
    logic in_retention;
  } ctl_state_all_t;
endpackage

// [design/sram_ctl.sv]
// master for a 64K x 1 asynchronous static memory with separate data in and out
// assumes the memory's output is sampled synchronously; one request at a time
`timescale 1ns/10ps
`include "sram_ctl_map.svh"
module sram_ctl (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire sram_ctl_pkg::mem_req_t req_i,
  input wire logic retain_req_i,
  input wire logic mem_q_i,
  output sram_ctl_pkg::mem_pins_t pins_o,
  output logic busy_o,
  output logic rvalid_o,
  output logic rdata_o,
  output logic in_retention_o
);
  import sram_ctl_pkg::*;

  localparam logic [`CNT_W-1:0] READ_CNT = (`CNT_W)'(`READ_CYCLE_CYC);
  localparam logic [`CNT_W-1:0] WRITE_CNT = (`CNT_W)'(`WRITE_PULSE_CYC);
  localparam logic [`CNT_W-1:0] RECOV_CNT = (`CNT_W)'(`RETENTION_RECOVERY_DELAY_CYC);
  localparam logic [`CNT_W-1:0] CNT_ONE = (`CNT_W)'(1);

  // a countdown ends on its last tick; zero ends it too, so a lost load cannot hang the machine
  function automatic logic last_tick(input logic [`CNT_W-1:0] cnt);
    last_tick = (cnt == CNT_ONE) || (cnt == '0);
  endfunction

  ctl_state_all_t s_r;
  ctl_state_all_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - CNT_ONE;
    end
    unique case (s_r.st)
      ST_IDLE: begin
        s_nxt.pins.sel_b = 1'b1;
        s_nxt.pins.wr_b = 1'b1;
        s_nxt.busy = 1'b0;
        if (retain_req_i) begin
          // select already high here, so deselect precedes retention
          s_nxt.st = ST_RETAIN;
          s_nxt.in_retention = 1'b1;
          s_nxt.busy = 1'b1;
        end else if (req_i.valid) begin
          // address and data placed a cycle ahead of any strobe
          s_nxt.pins.cell_index = req_i.cell_index;
          s_nxt.pins.din = req_i.wdata;
          s_nxt.pins.wr_b = 1'b1;
          s_nxt.busy = 1'b1;
          s_nxt.st = ST_SETUP;
          s_nxt.rdata = req_i.write;
        end
      end
      ST_SETUP: begin
        s_nxt.pins.sel_b = 1'b0;
        if (s_r.rdata) begin
          s_nxt.pins.wr_b = 1'b0;
          s_nxt.cnt = WRITE_CNT;
          s_nxt.st = ST_WRITE;
        end else begin
          s_nxt.pins.wr_b = 1'b1;
          s_nxt.cnt = READ_CNT;
          s_nxt.st = ST_READ;
        end
      end
      ST_READ: begin
        if (last_tick(s_r.cnt)) begin
          // sample only after a full read cycle time so the new cell has settled
          s_nxt.rdata = mem_q_i;
          s_nxt.rvalid = 1'b1;
          s_nxt.pins.sel_b = 1'b1;
          s_nxt.st = ST_IDLE;
          s_nxt.busy = 1'b0;
        end
      end
      ST_WRITE: begin
        if (last_tick(s_r.cnt)) begin
          // strobe and select rise together on the same edge; data and address hold past write end
          s_nxt.pins.wr_b = 1'b1;
          s_nxt.pins.sel_b = 1'b1;
          s_nxt.st = ST_IDLE;
          s_nxt.busy = 1'b0;
        end
      end
      ST_RETAIN: begin
        s_nxt.pins.sel_b = 1'b1;
        if (!retain_req_i) begin
          s_nxt.in_retention = 1'b0;
          s_nxt.cnt = RECOV_CNT;
          s_nxt.st = ST_RECOV;
        end
      end
      ST_RECOV: begin
        // select stays high for the whole recovery, so no access can start early
        if (last_tick(s_r.cnt)) begin
          s_nxt.st = ST_IDLE;
          s_nxt.busy = 1'b0;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
        s_nxt.pins.sel_b = 1'b1;
        s_nxt.pins.wr_b = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r.st <= ST_IDLE;
      s_r.cnt <= '0;
      s_r.pins.sel_b <= 1'b1;
      s_r.pins.wr_b <= 1'b1;
      s_r.pins.cell_index <= `CELL_INDEX_RST;
      s_r.pins.din <= 1'b0;
      s_r.busy <= 1'b0;
      s_r.rvalid <= 1'b0;
      s_r.rdata <= 1'b0;
      s_r.in_retention <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pins_o = s_r.pins;
  assign busy_o = s_r.busy;
  assign rvalid_o = s_r.rvalid;
  assign rdata_o = s_r.rdata;
  assign in_retention_o = s_r.in_retention;
endmodule // sram_ctl

// [sim/sram_ctl_assertions.sv]
// pin sequencing checks for sram_ctl
// sees only the controller ports
`timescale 1ns/10ps
module sram_ctl_assertions (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire sram_ctl_pkg::mem_pins_t pins_o,
  input wire logic busy_o,
  input wire logic rvalid_o,
  input wire logic in_retention_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_strobe; !pins_o.sel_b && $past(!pins_o.sel_b) |-> $stable(pins_o.wr_b); endproperty
  a_strobe: assert property (p_strobe) else $error("strobe moved while selected");
  property p_held; !pins_o.sel_b |-> $stable(pins_o.cell_index) && $stable(pins_o.din); endproperty
  a_held: assert property (p_held) else $error("index moved while selected");
  property p_wr; $fell(pins_o.wr_b) |-> !pins_o.sel_b ##1 (pins_o.sel_b && pins_o.wr_b); endproperty
  a_wr: assert property (p_wr) else $error("write span wrong");
  property p_rd; $fell(pins_o.sel_b) && pins_o.wr_b |-> ##2 (rvalid_o && pins_o.sel_b); endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_ret; in_retention_o |-> pins_o.sel_b && busy_o; endproperty
  a_ret: assert property (p_ret) else $error("selected in retention");
  property p_rec; $fell(in_retention_o) |-> (pins_o.sel_b && busy_o) [*2]; endproperty
  a_rec: assert property (p_rec) else $error("recovery too short");
endmodule // sram_ctl_assertions

// [sim/mem_model.sv]
// behavioural 64K x 1 memory
// output shows the inverse of its last value while floating
`timescale 1ns/10ps
module mem_model (
  input wire sram_ctl_pkg::mem_pins_t pins_i,
  output logic q_o
);
  logic cells [0:65535];
  logic last_q = 1'b0;
  always @* if (!pins_i.sel_b && !pins_i.wr_b) cells[pins_i.cell_index] = pins_i.din;
  always @* if (!pins_i.sel_b && pins_i.wr_b) last_q = cells[pins_i.cell_index];
  assign q_o = (!pins_i.sel_b && pins_i.wr_b) ? last_q : ~last_q;
endmodule // mem_model

// [sim/sram_ctl_tb.sv]
// self-checking bench for sram_ctl
// assumes package and map header compiled first
`timescale 1ns/10ps
`include "sram_ctl_map.svh"
module sram_ctl_tb;
  import sram_ctl_pkg::*;
  logic clk = 0, rst_b = 0, retain = 0, q, busy, rvalid, rdata, in_ret;
  mem_req_t req = '0;
  mem_pins_t pins;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  sram_ctl dut (.ref_clk_i(clk), .rst_b_i(rst_b), .req_i(req), .retain_req_i(retain), .mem_q_i(q),
    .pins_o(pins), .busy_o(busy), .rvalid_o(rvalid), .rdata_o(rdata), .in_retention_o(in_ret));
  mem_model mem (.pins_i(pins), .q_o(q));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [`CELL_INDEX_W-1:0] idx, input logic d);
    int n = 0;
    req = '{1'b1, wr, idx, d};
    @(posedge clk) #2 req.valid = 1'b0;
    while (busy === 1'b1 && n < 20) begin
      @(posedge clk) #2 n++;
    end
    chk(8'(n), 8'(wr ? 1 + `WRITE_PULSE_CYC : 1 + `READ_CYCLE_CYC));
    chk(rvalid, !wr);
    if (!wr) chk(rdata, d);
  endtask
  task automatic t_rw();
    access(1'b1, 16'hffff, 1'b1);
    access(1'b1, 16'h0000, 1'b0);
    access(1'b1, 16'h5a5a, 1'b1);
    access(1'b0, 16'hffff, 1'b1);
    access(1'b0, 16'h0000, 1'b0);
    access(1'b1, 16'h5a5a, 1'b0);
    access(1'b0, 16'h5a5a, 1'b0);
    $display("read write test done");
  endtask
  task automatic t_retain();
    int n = 0;
    retain = 1'b1;
    @(posedge clk) #2 chk({in_ret, pins.sel_b, busy}, 3'b111);
    retain = 1'b0;
    while (busy === 1'b1 && n < 20) begin
      @(posedge clk) #2 n++;
    end
    chk(n >= `READ_CYCLE_CYC, 1'b1);
    access(1'b0, 16'hffff, 1'b1);
    $display("retention test done");
  endtask
  task automatic t_reset();
    req = '{1'b1, 1'b0, 16'hffff, 1'b0};
    @(posedge clk) #2 req.valid = 1'b0;
    @(posedge clk) #2 rst_b = 1'b0;
    #1 chk({pins.sel_b, pins.wr_b, busy, rvalid, in_ret}, 5'b11000);
    repeat (2) @(posedge clk);
    #2 rst_b = 1'b1;
    @(posedge clk) #2 chk({pins.sel_b, pins.wr_b, busy}, 3'b110);
    access(1'b0, 16'hffff, 1'b1);
    $display("mid-run reset test done");
  endtask
  task automatic give_verdict();
    $display("%0d comparisons, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #2 rst_b = 1'b1;
    chk({pins.sel_b, pins.wr_b, busy, rvalid, in_ret}, 5'b11000);
    $display("reset test done");
    t_rw();
    t_retain();
    t_reset();
    give_verdict();
  end
  // far above the few dozen cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      give_verdict();
    end
  end
endmodule // sram_ctl_tb
bind sram_ctl sram_ctl_assertions chk_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .pins_o(pins_o),
  .busy_o(busy_o), .rvalid_o(rvalid_o), .in_retention_o(in_retention_o));
